//--- logic/lite_timer_pkg.sv
// Constants, register map and field layout of the dual timebase capture timer.
// Assumes a 32-bit AXI4-Lite register bus and a single timer clock.
package lite_timer_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned PRESCALE_DIV = 32;
  localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE_DIV - 1);
  localparam logic [7:0] TB1_FIRST = 8'h00;
  localparam logic [7:0] TB1_LAST = 8'hf9;
  localparam logic [7:0] CNT2_LAST = 8'hff;
  localparam int unsigned TB1_PERIOD_OSC = 8000;
  localparam int unsigned TB1_PERIOD_DBL_OSC = 16000;
  localparam int unsigned TB1_STATES = TB1_PERIOD_OSC / PRESCALE_DIV;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0] IDX_TB2_CSR = 8'h08;
  localparam logic [7:0] IDX_RELOAD = 8'h09;
  localparam logic [7:0] IDX_CNT2 = 8'h0a;
  localparam logic [7:0] IDX_TB1_CSR = 8'h0b;
  localparam logic [7:0] IDX_CAPTURE = 8'h0c;

  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction

  localparam logic [7:0] ADDR_TB2_CSR = reg_addr(IDX_TB2_CSR);
  localparam logic [7:0] ADDR_RELOAD = reg_addr(IDX_RELOAD);
  localparam logic [7:0] ADDR_CNT2 = reg_addr(IDX_CNT2);
  localparam logic [7:0] ADDR_TB1_CSR = reg_addr(IDX_TB1_CSR);
  localparam logic [7:0] ADDR_CAPTURE = reg_addr(IDX_CAPTURE);

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned TIMEBASE2_OVERFLOW_FLAG_BIT = 0;
  localparam int unsigned TIMEBASE2_IRQ_ENABLE_BIT = 1;
  localparam int unsigned TIMEBASE1_OVERFLOW_FLAG_BIT = 3;
  localparam int unsigned TIMEBASE1_IRQ_ENABLE_BIT = 4;
  localparam int unsigned PERIOD_SEL_BIT = 5;
  localparam int unsigned ICF_BIT = 6;
  localparam int unsigned CAPTURE_IRQ_ENABLE_BIT = 7;

  // ----------------------------------------
  // Reset values and bus answers
  // ----------------------------------------
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_CAPTURE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- logic/timer_link_if.sv
// Carrier between the timer core and its timebase and capture helpers.
// Assumes all parties run on the same clock.
`timescale 1ns/10ps
interface timer_link_if;
  logic tick;
  logic ovf1;
  logic [7:0] count1;
  logic cap_strobe;

  modport timebase (output tick, output ovf1, output count1);
  modport capture (output cap_strobe);
  modport core (input tick, input ovf1, input count1, input cap_strobe);
endinterface

//--- logic/timebase1_counter.sv
// Divide-by-32 prescaler and free-running 250-state timebase counter.
// Assumes ce freezes everything and halt only stops counting.
`timescale 1ns/10ps
module timebase1_counter
  import lite_timer_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic halt,
  // Select and link
  input wire logic period_double_select,
  timer_link_if.timebase link
);
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] cnt1;
    logic half;
    logic tick;
    logic ovf1;
  } tb_s;

  tb_s q_r;
  tb_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.tick = 1'b0;
    q_nxt.ovf1 = 1'b0;
    if (!halt) begin
      q_nxt.pre = q_r.pre + 5'h01;
      if (q_r.pre == PRESCALE_LAST) begin
        q_nxt.tick = 1'b1;
        if (q_r.cnt1 == TB1_LAST) begin
          q_nxt.cnt1 = TB1_FIRST;
          // Doubled period skips every other wrap
          q_nxt.half = period_double_select ? !q_r.half : 1'b0;
          q_nxt.ovf1 = !period_double_select || q_r.half;
        end else begin
          q_nxt.cnt1 = q_r.cnt1 + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign link.tick = q_r.tick;
  assign link.ovf1 = q_r.ovf1;
  assign link.count1 = q_r.cnt1;
endmodule

//--- logic/capture_edge_detect.sv
// Two-stage synchroniser and both-edge detector for the capture pin.
// Assumes the pin may change at any time relative to aclk.
`timescale 1ns/10ps
module capture_edge_detect (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Pin and link
  input wire logic capture_input_pin,
  timer_link_if.capture link
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic strobe;
  } cap_s;

  cap_s q_r;
  cap_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.sync1 = capture_input_pin;
    q_nxt.sync2 = q_r.sync1;
    q_nxt.last = q_r.sync2;
    // Only the second stage feeds the comparator
    q_nxt.strobe = q_r.sync2 ^ q_r.last;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign link.cap_strobe = q_r.strobe;
endmodule

//--- logic/dual_timebase_capture_timer.sv
// Top of the dual timebase capture timer with its AXI4-Lite register slave.
// Assumes one 20 MHz clock, synchronous mode pins, an asynchronous capture pin and an external global irq mask.
//
// What this block does
// - Hidden 8-bit counter one, ticks every 32 clocks
// - Counter one wraps F9h to 00h, overflow
// - Period select doubles overflow period to 16000
// - Overflow sets flag one, enable raises request
// - Reading first status register clears flag one
// - Readable counter two starts from reload value
// - Counter two past FFh loads reload value
// - Reload write takes effect at next overflow
// - Counter two overflow sets flag two, request
// - Reading second status register clears flag two
// - Pin edge copies counter one, sets capture flag
// - Set capture flag blocks further captures
// - Reading capture register clears capture flag
// - Capture register read-only, reset zero, last capture
// - Halt stops both counters, other modes don't
// - Requests need enable and clear global mask
`timescale 1ns/10ps
module dual_timebase_capture_timer
  import lite_timer_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // System mode
  input wire logic halt,
  input wire logic global_irq_mask,
  // Capture pin
  input wire logic capture_input_pin,
  // Interrupt requests
  output logic irq_timebase1,
  output logic irq_timebase2,
  output logic irq_capture,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import lite_timer_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  timer_link_if link ();
  logic period_sel_w;

  timebase1_counter u_timebase1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .halt(halt),
    .period_double_select(period_sel_w),
    .link(link.timebase)
  );

  capture_edge_detect u_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .capture_input_pin(capture_input_pin),
    .link(link.capture)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] counter2_reload;
    logic [7:0] counter2_value;
    logic [7:0] captured_count;
    logic timebase1_overflow_flag;
    logic timebase2_overflow_flag;
    logic capture_flag;
    logic period_double_select;
    logic timebase1_irq_enable;
    logic timebase2_irq_enable;
    logic capture_irq_enable;
  } core_s;

  core_s q_r;
  core_s q_nxt;

  assign period_sel_w = q_r.period_double_select;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == ADDR_TB2_CSR) || (addr == ADDR_RELOAD) ||
                (addr == ADDR_CNT2) || (addr == ADDR_TB1_CSR) ||
                (addr == ADDR_CAPTURE);
  endfunction

  logic [7:0] wr_addr_w;
  logic [7:0] rd_addr_w;
  logic do_write;
  logic ar_take;
  logic [7:0] csr1_view;
  logic [7:0] csr2_view;

  assign wr_addr_w = q_r.aw_addr;
  assign rd_addr_w = s_axi_araddr[7:0];
  assign do_write = q_r.aw_held && q_r.w_held && !q_r.bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Reserved positions always read back as zero
  always_comb begin
    csr2_view = 8'h00;
    csr2_view[TIMEBASE2_OVERFLOW_FLAG_BIT] = q_r.timebase2_overflow_flag;
    csr2_view[TIMEBASE2_IRQ_ENABLE_BIT] = q_r.timebase2_irq_enable;
    csr1_view = 8'h00;
    csr1_view[TIMEBASE1_OVERFLOW_FLAG_BIT] = q_r.timebase1_overflow_flag;
    csr1_view[TIMEBASE1_IRQ_ENABLE_BIT] = q_r.timebase1_irq_enable;
    csr1_view[PERIOD_SEL_BIT] = q_r.period_double_select;
    csr1_view[ICF_BIT] = q_r.capture_flag;
    csr1_view[CAPTURE_IRQ_ENABLE_BIT] = q_r.capture_irq_enable;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    q_nxt = q_r;

    // Write address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      q_nxt.aw_held = 1'b1;
      q_nxt.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      q_nxt.w_held = 1'b1;
      q_nxt.w_data = s_axi_wdata[7:0];
      q_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end

    // Register writes; flag positions ignore written data
    if (do_write) begin
      q_nxt.aw_held = 1'b0;
      q_nxt.w_held = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = is_mapped(wr_addr_w) ? RESP_OKAY : RESP_SLVERR;
      if (q_r.w_lane0) begin
        case (wr_addr_w)
          ADDR_TB2_CSR: begin
            q_nxt.timebase2_irq_enable = q_r.w_data[TIMEBASE2_IRQ_ENABLE_BIT];
          end
          ADDR_RELOAD: begin
            // Held aside until the next counter two overflow
            q_nxt.counter2_reload = q_r.w_data;
          end
          ADDR_TB1_CSR: begin
            q_nxt.capture_irq_enable = q_r.w_data[CAPTURE_IRQ_ENABLE_BIT];
            q_nxt.period_double_select = q_r.w_data[PERIOD_SEL_BIT];
            q_nxt.timebase1_irq_enable = q_r.w_data[TIMEBASE1_IRQ_ENABLE_BIT];
          end
          default: begin
          end
        endcase
      end
    end

    // Reads: answer with the value before any clear
    if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = is_mapped(rd_addr_w) ? RESP_OKAY : RESP_SLVERR;
      case (rd_addr_w)
        ADDR_TB2_CSR: begin
          q_nxt.rdata = csr2_view;
          q_nxt.timebase2_overflow_flag = 1'b0;
        end
        ADDR_RELOAD: begin
          q_nxt.rdata = q_r.counter2_reload;
        end
        ADDR_CNT2: begin
          q_nxt.rdata = q_r.counter2_value;
        end
        ADDR_TB1_CSR: begin
          q_nxt.rdata = csr1_view;
          q_nxt.timebase1_overflow_flag = 1'b0;
        end
        ADDR_CAPTURE: begin
          q_nxt.rdata = q_r.captured_count;
          q_nxt.capture_flag = 1'b0;
        end
        default: begin
          q_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Counter two; the tick already stops in halt
    if (link.tick) begin
      if (q_r.counter2_value == CNT2_LAST) begin
        q_nxt.counter2_value = q_r.counter2_reload;
        q_nxt.timebase2_overflow_flag = 1'b1;
      end else begin
        q_nxt.counter2_value = q_r.counter2_value + 8'h01;
      end
    end

    // Hardware set wins over a read clear in the same cycle
    if (link.ovf1) begin
      q_nxt.timebase1_overflow_flag = 1'b1;
    end

    // A pending flag blocks capture and keeps the old value
    if (link.cap_strobe && !q_r.capture_flag) begin
      q_nxt.captured_count = link.count1;
      q_nxt.capture_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
      q_r.bresp <= RESP_OKAY;
      q_r.rresp <= RESP_OKAY;
      // Counter two starts from the reset reload value
      q_r.counter2_reload <= RST_RELOAD;
      q_r.counter2_value <= RST_RELOAD;
      q_r.captured_count <= RST_CAPTURE;
      // Cleared here; software still reads the capture register once
      q_r.capture_flag <= 1'b0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // One write and one read outstanding; no pipelining needed at this rate
  assign s_axi_awready = !q_r.aw_held && !q_r.bvalid && ce;
  assign s_axi_wready = !q_r.w_held && !q_r.bvalid && ce;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = !q_r.rvalid && ce;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rresp = q_r.rresp;
  assign s_axi_rdata = {24'h000000, q_r.rdata};

  // Separate request lines, one per vector
  assign irq_timebase1 = q_r.timebase1_overflow_flag && q_r.timebase1_irq_enable &&
                         !global_irq_mask;
  assign irq_timebase2 = q_r.timebase2_overflow_flag && q_r.timebase2_irq_enable &&
                         !global_irq_mask;
  assign irq_capture = q_r.capture_flag && q_r.capture_irq_enable &&
                       !global_irq_mask;

endmodule

//--- verif/capture_pin_source.sv
// Model of the signal source wired to the capture pin.
// Assumes requests come as one-cycle pulses on aclk.
`timescale 1ns/10ps
module capture_pin_source (
  // Clock and command
  input wire logic aclk,
  input wire logic flip_req,
  input wire logic [3:0] lag,
  // Pin
  output logic capture_input_pin
);
  int wait_n = -1;
  initial capture_input_pin = 1'b0;
  // Toggle lag+1 cycles after the request is sampled, 13 ns off the edge like a real source
  always @(posedge aclk) begin
    if (flip_req) begin
      wait_n = int'(lag);
    end else if (wait_n == 0) begin
      #13 capture_input_pin = !capture_input_pin;
      wait_n = -1;
    end else if (wait_n > 0) begin
      wait_n = wait_n - 1;
    end
  end
endmodule

//--- verif/dual_timebase_capture_timer_checker.sv
// Concurrent checks on the timer's top-level pins.
// Assumes one clock domain and the package's byte map.
`timescale 1ns/10ps
module dual_timebase_capture_timer_checker
  import lite_timer_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and mode
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic global_irq_mask,
  // Requests
  input wire logic irq_timebase1,
  input wire logic irq_timebase2,
  input wire logic irq_capture,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic ar_go = s_axi_arvalid && s_axi_arready;
  wire logic w_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  property p_mask;
    global_irq_mask |-> !(irq_timebase1 || irq_timebase2 || irq_capture);
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_clr1;
    ar_go && s_axi_araddr == ADDR_TB1_CSR |=> !irq_timebase1;
  endproperty
  a_clr1: assert property (p_clr1) else $error("flag one kept");
  property p_clr2;
    ar_go && s_axi_araddr == ADDR_TB2_CSR |=> !irq_timebase2;
  endproperty
  a_clr2: assert property (p_clr2) else $error("flag two kept");
  property p_clrc;
    ar_go && s_axi_araddr == ADDR_CAPTURE |=> !irq_capture;
  endproperty
  a_clrc: assert property (p_clrc) else $error("capture flag kept");
  property p_rlat;
    ar_go |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read late");
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("second read taken");
  property p_rhigh;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rhigh: assert property (p_rhigh) else $error("upper data set");
  property p_blat;
    w_go |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write response late");
  property p_bonce;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bonce: assert property (p_bonce) else $error("response repeated");
  cover property ($rose(irq_capture));
  cover property ($rose(irq_timebase2));
  cover property (ar_go && s_axi_araddr == ADDR_CAPTURE);
endmodule
bind dual_timebase_capture_timer dual_timebase_capture_timer_checker #(.ADDR_W(ADDR_W)) chk (.*);

//--- verif/dual_timebase_capture_timer_tb.sv
// Self-checking bench of the capture timer, one task per scenario.
// Assumes the package byte map and a 50 ns clock.
`timescale 1ns/10ps
module dual_timebase_capture_timer_tb;
  import lite_timer_pkg::*;
  logic aclk, aresetn, ce, halt, global_irq_mask, capture_input_pin, flip_req;
  logic irq_timebase1, irq_timebase2, irq_capture;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb, lag;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, v2;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int num_errors = 0;
  int total_checks = 0;
  realtime t0, t1;
  wire logic [2:0] irqv = {irq_capture, irq_timebase2, irq_timebase1};
  dual_timebase_capture_timer #(.ADDR_W(8)) uut (.*);
  capture_pin_source src (.aclk(aclk), .flip_req(flip_req), .lag(lag),
    .capture_input_pin(capture_input_pin));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    give_up(n, 40);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    give_up(n, 40);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    rd(a, d, er);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  task automatic wirq(input int i, output realtime t);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge aclk);
      if (irqv[i] === 1'b1) break;
    end
    give_up(n, 20000);
    t = $realtime;
  endtask
  task automatic flip(input logic [3:0] l);
    @(posedge aclk);
    lag <= l;
    flip_req <= 1'b1;
    @(posedge aclk);
    flip_req <= 1'b0;
    repeat (24) @(posedge aclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdx(ADDR_CAPTURE, 32'h0, RESP_OKAY);
    rdx(ADDR_TB2_CSR, 32'h0, RESP_OKAY);
    rdx(ADDR_RELOAD, 32'h0, RESP_OKAY);
    rdx(ADDR_CNT2, 32'h0, RESP_OKAY);
    rdx(ADDR_TB1_CSR, 32'h0, RESP_OKAY);
    rdx(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h00, 32'h5a, RESP_SLVERR);
    wr(ADDR_CAPTURE, 32'h5a, RESP_OKAY);
    rdx(ADDR_CAPTURE, 32'h0, RESP_OKAY);
    $display("reset test done");
  endtask
  // Counter two tracks counter one until counter one first wraps at F9h, so it predicts captures
  task automatic t_capture();
    wr(ADDR_TB1_CSR, 32'h80, RESP_OKAY);
    repeat (40) @(posedge aclk);
    halt <= 1'b1;
    rd(ADDR_CNT2, v, RESP_OKAY);
    flip(4'h0);
    chk("irq_capture", 32'(irq_capture), 32'h1);
    rdx(ADDR_TB1_CSR, 32'hc0, RESP_OKAY);
    halt <= 1'b0;
    repeat (100) @(posedge aclk);
    halt <= 1'b1;
    flip(4'h9);
    rd(ADDR_CNT2, v2, RESP_OKAY);
    repeat (100) @(posedge aclk);
    rdx(ADDR_CNT2, v2, RESP_OKAY);
    rdx(ADDR_CAPTURE, v, RESP_OKAY);
    rdx(ADDR_TB1_CSR, 32'h80, RESP_OKAY);
    flip(4'h2);
    rdx(ADDR_CAPTURE, v2, RESP_OKAY);
    halt <= 1'b0;
    $display("capture test done");
  endtask
  task automatic t_reload();
    halt <= 1'b1;
    rd(ADDR_CNT2, v, RESP_OKAY);
    wr(ADDR_RELOAD, 32'hf0, RESP_OKAY);
    wr(ADDR_TB2_CSR, 32'h03, RESP_OKAY);
    rdx(ADDR_CNT2, v, RESP_OKAY);
    rdx(ADDR_TB2_CSR, 32'h02, RESP_OKAY);
    halt <= 1'b0;
    wirq(1, t0);
    rdx(ADDR_CNT2, 32'hf0, RESP_OKAY);
    global_irq_mask <= 1'b1;
    @(posedge aclk);
    chk("irq_timebase2", 32'(irq_timebase2), 32'h0);
    global_irq_mask <= 1'b0;
    @(posedge aclk);
    chk("irq_timebase2", 32'(irq_timebase2), 32'h1);
    rdx(ADDR_TB2_CSR, 32'h03, RESP_OKAY);
    rdx(ADDR_TB2_CSR, 32'h02, RESP_OKAY);
    wirq(1, t1);
    chk("tb2 period", 32'(int'((t1 - t0) / 50)), 32'd512);
    $display("reload test done");
  endtask
  task automatic t_timebase();
    wr(ADDR_TB1_CSR, 32'h10, RESP_OKAY);
    rd(ADDR_TB1_CSR, v, RESP_OKAY);
    wirq(0, t0);
    rdx(ADDR_TB1_CSR, 32'h18, RESP_OKAY);
    rdx(ADDR_TB1_CSR, 32'h10, RESP_OKAY);
    wirq(0, t1);
    chk("tb1 period", 32'(int'((t1 - t0) / 50)), 32'd8000);
    wr(ADDR_TB1_CSR, 32'h30, RESP_OKAY);
    rd(ADDR_TB1_CSR, v, RESP_OKAY);
    wirq(0, t0);
    rdx(ADDR_TB1_CSR, 32'h38, RESP_OKAY);
    wirq(0, t1);
    chk("tb1 double", 32'(int'((t1 - t0) / 50)), 32'd16000);
    $display("timebase test done");
  endtask
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    halt = 1'b0;
    global_irq_mask = 1'b0;
    flip_req = 1'b0;
    lag = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_capture();
    t_reload();
    t_timebase();
    conclude();
  end
endmodule
